// >>> design/pwr_ctrl_consts.svh
// Purpose: constants for the power key, reset and lamp control ends
// Assumes: 100 MHz clock, 1 ms tick from a divider
// Notes: all times in ms; counts in ms ticks
`ifndef PWR_CTRL_CONSTS_SVH
`define PWR_CTRL_CONSTS_SVH
`define CLK_MHZ          100
// clocks per ms tick: CLK_MHZ * 1000 in silicon, kept short for simulation
`define MS_CYCLES        4
`define TURN_ON_MS       500
`define TURN_ON_MAX_MS   1000
`define TURN_OFF_MS      2500
`define TURN_OFF_MAX_MS  4000
`define DPLUS_MS         4000
`define RST_MIN_MS       50
`define RST_OFF_MS       2000
`define HOST_ON_MS       750
`define HOST_OFF_MS      3000
`define HOST_RST_MS      100
`define DEB_MS           5
`define POR_MS           10
`define REPORT_MS        1
`define SINGLE_ON_MS     100
`define SINGLE_OFF_MS    1800
`define FAST_ON_MS       125
`define FAST_OFF_MS      125
`define DOUBLE_ON_MS     100
`define DOUBLE_GAP_MS    100
`define DOUBLE_OFF_MS    1700
`define CNT_W            13
`endif

// >>> design/pwr_ctrl_pkg.sv
// Purpose: shared types for the power control ends
// Assumes: nothing
// Notes: network states drive the lamp patterns
package pwr_ctrl_pkg;
   typedef enum logic [2:0] {
      NET_IDLE   = 3'b000,
      NET_3G_REG = 3'b001,
      NET_3G_DATA= 3'b010,
      NET_UPDATE = 3'b011,
      NET_SEARCH = 3'b100,
      NET_2G_REG = 3'b101,
      NET_2G_DATA= 3'b110
   } net_state_t;
   typedef enum logic [2:0] {
      PWR_OFF     = 3'b000,
      PWR_POR     = 3'b001,
      PWR_BOOT    = 3'b010,
      PWR_ON      = 3'b011,
      PWR_RST     = 3'b100
   } pwr_state_t;
endpackage

// >>> design/pwr_ctrl_if.sv
// Purpose: pin bundle between host terminal and module control
// Assumes: one shared clock
// Notes: all pins are plain one-way levels
`timescale 1ns/1ps
interface pwr_ctrl_if;
   logic power_key_n;
   logic hw_reset_low_input;
   logic network_status_lamp;
   logic network_mode_lamp;
   logic usb_dplus_up;
   logic wake_host;
   logic sleep_ctrl;
   logic sleep_ctrl_driven;
   modport module_end (input power_key_n, hw_reset_low_input, sleep_ctrl, sleep_ctrl_driven,
                       output network_status_lamp, network_mode_lamp, usb_dplus_up,
                       wake_host);
   modport host_end (output power_key_n, hw_reset_low_input, sleep_ctrl, sleep_ctrl_driven,
                     input network_status_lamp, network_mode_lamp, usb_dplus_up, wake_host);
endinterface

// >>> design/module_ctrl.sv
// Purpose: module end: power key, reset, boot, lamps, wake pins
// Assumes: host keeps its press and reset windows
// Notes: times counted on a 1 ms tick
`timescale 1ns/1ps
`include "pwr_ctrl_consts.svh"
module module_ctrl (
   // clock and reset
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_nrst,
   // pins
   pwr_ctrl_if.module_end               pins,
   // internal status
   input  wire logic                    i_supply_ok,
   input  wire pwr_ctrl_pkg::net_state_t i_net_state,
   input  wire logic                    i_need_host,
   // status out
   output logic                         o_powered,
   output logic                         o_awake,
   output logic                         o_comms_en,
   output logic                         o_startup_report
);
   import pwr_ctrl_pkg::*;

   logic [16:0]    div;
   logic [16:0]    next_div;
   logic           tick;
   logic           next_tick;
   logic [1:0]     key_sync;
   logic [1:0]     rst_sync;
   logic [1:0]     slp_sync;
   logic [1:0]     drv_sync;
   logic [2:0]     key_deb;
   logic [2:0]     rst_deb;
   logic [`CNT_W-1:0] key_cnt;
   logic [`CNT_W-1:0] next_key_cnt;
   logic [`CNT_W-1:0] rst_cnt;
   logic [`CNT_W-1:0] next_rst_cnt;
   logic [`CNT_W-1:0] tmr;
   logic [`CNT_W-1:0] next_tmr;
   logic           key_low;
   logic           rst_low;
   logic           key_done;
   logic           next_key_done;
   logic           rst_armed;
   logic           next_rst_armed;
   pwr_state_t     st;
   pwr_state_t     next_st;
   logic           seen_drive;
   logic           next_seen_drive;
   logic [`CNT_W-1:0] blk;
   logic [`CNT_W-1:0] next_blk;
   logic           s_lamp;
   logic           m_lamp;
   logic           next_s_lamp;
   logic           next_m_lamp;
   logic           next_report;

   // 1 ms tick and input debounce on tick
   always_comb begin
      next_tick = 1'b0;
      next_div  = div + 17'h0_0001;
      if (div == 17'(`MS_CYCLES - 1)) begin
         next_div  = 17'h0_0000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div      <= 17'h0_0000;
         tick     <= 1'b0;
         key_sync <= 2'h3;
         rst_sync <= 2'h3;
         slp_sync <= 2'h3;
         drv_sync <= 2'h0;
         key_deb  <= 3'h7;
         rst_deb  <= 3'h7;
      end else begin
         div      <= next_div;
         tick     <= next_tick;
         key_sync <= {key_sync[0], pins.power_key_n};
         rst_sync <= {rst_sync[0], pins.hw_reset_low_input};
         slp_sync <= {slp_sync[0], pins.sleep_ctrl};
         drv_sync <= {drv_sync[0], pins.sleep_ctrl_driven};
         if (tick) begin
            key_deb <= {key_deb[1:0], key_sync[1]};
            rst_deb <= {rst_deb[1:0], rst_sync[1]};
         end
      end
   end

   assign key_low = (key_deb == 3'h0);
   assign rst_low = (rst_deb == 3'h0);

   // low-time counters from the falling edge
   always_comb begin
      next_key_cnt = key_cnt;
      next_rst_cnt = rst_cnt;
      if (!key_low) next_key_cnt = '0;
      else if (tick && key_cnt != '1) next_key_cnt = key_cnt + 1'b1;
      if (!rst_low) next_rst_cnt = '0;
      else if (tick && rst_cnt != '1) next_rst_cnt = rst_cnt + 1'b1;
   end

   // power sequencer
   always_comb begin
      next_st         = st;
      next_tmr        = tmr;
      next_key_done   = key_done & key_low;
      next_rst_armed  = rst_armed;
      next_report     = 1'b0;
      next_seen_drive = seen_drive | drv_sync[1];
      if (tick && tmr != '0) next_tmr = tmr - 1'b1;
      unique case (st)
         PWR_OFF: begin
            next_seen_drive = 1'b0;
            if (i_supply_ok && key_low && !key_done &&
                key_cnt >= `CNT_W'(`TURN_ON_MS)) begin
               next_st       = PWR_POR;
               next_key_done = 1'b1;
               next_tmr      = `CNT_W'(`POR_MS);
            end
         end
         PWR_POR: begin
            if (tmr == '0) begin
               next_st  = PWR_BOOT;
               next_tmr = `CNT_W'(`DPLUS_MS - `POR_MS);
            end
         end
         PWR_BOOT: begin
            if (tmr == '0) begin
               next_st     = PWR_ON;
               next_report = rst_armed;
               next_rst_armed = 1'b0;
            end
         end
         PWR_ON: begin
            if (key_low && !key_done && key_cnt >= `CNT_W'(`TURN_OFF_MS)) begin
               next_st       = PWR_OFF;
               next_key_done = 1'b1;
            end else if (rst_low) begin
               next_st = PWR_RST;
            end
         end
         PWR_RST: begin
            if (rst_cnt >= `CNT_W'(`RST_OFF_MS)) begin
               next_st = PWR_OFF;
            end else if (!rst_low) begin
               next_st  = rst_armed ? PWR_POR : PWR_ON;
               next_tmr = `CNT_W'(`POR_MS);
            end
            if (rst_low && rst_cnt >= `CNT_W'(`RST_MIN_MS)) next_rst_armed = 1'b1;
         end
         default: next_st = PWR_OFF;
      endcase
      if (!i_supply_ok) next_st = PWR_OFF;
   end

   // reset release: rst_cnt clears on release; armed reset reboots
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st         <= PWR_OFF;
         tmr        <= '0;
         key_cnt    <= '0;
         rst_cnt    <= '0;
         key_done   <= 1'b0;
         rst_armed  <= 1'b0;
         seen_drive <= 1'b0;
      end else begin
         st         <= next_st;
         tmr        <= next_tmr;
         key_cnt    <= next_key_cnt;
         rst_cnt    <= next_rst_cnt;
         key_done   <= next_key_done;
         rst_armed  <= next_rst_armed;
         seen_drive <= next_seen_drive;
      end
   end

   // lamp patterns on a ms phase counter
   always_comb begin
      next_blk    = blk;
      next_s_lamp = 1'b0;
      next_m_lamp = 1'b0;
      if (tick) next_blk = blk + 1'b1;
      unique case (i_net_state)
         NET_3G_REG: begin
            if (blk >= `CNT_W'(`SINGLE_ON_MS + `SINGLE_OFF_MS - 1) && tick) next_blk = '0;
            next_s_lamp = (blk < `CNT_W'(`SINGLE_ON_MS));
         end
         NET_3G_DATA: next_s_lamp = 1'b1;
         NET_UPDATE: begin
            if (blk >= `CNT_W'(`FAST_ON_MS + `FAST_OFF_MS - 1) && tick) next_blk = '0;
            next_m_lamp = (blk < `CNT_W'(`FAST_ON_MS));
         end
         NET_SEARCH: begin
            if (blk >= `CNT_W'(2 * `DOUBLE_ON_MS + `DOUBLE_GAP_MS + `DOUBLE_OFF_MS - 1)
                && tick) next_blk = '0;
            next_m_lamp = (blk < `CNT_W'(`DOUBLE_ON_MS)) ||
                          (blk >= `CNT_W'(`DOUBLE_ON_MS + `DOUBLE_GAP_MS) &&
                           blk < `CNT_W'(2 * `DOUBLE_ON_MS + `DOUBLE_GAP_MS));
         end
         NET_2G_REG: begin
            if (blk >= `CNT_W'(`SINGLE_ON_MS + `SINGLE_OFF_MS - 1) && tick) next_blk = '0;
            next_m_lamp = (blk < `CNT_W'(`SINGLE_ON_MS));
         end
         NET_2G_DATA: next_m_lamp = 1'b1;
         default: next_blk = '0;
      endcase
      if (st != PWR_ON) begin
         next_s_lamp = 1'b0;
         next_m_lamp = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         blk                      <= '0;
         s_lamp                   <= 1'b0;
         m_lamp                   <= 1'b0;
         pins.network_status_lamp <= 1'b1;
         pins.network_mode_lamp   <= 1'b1;
         pins.usb_dplus_up        <= 1'b0;
         pins.wake_host           <= 1'b0;
         o_powered                <= 1'b0;
         o_awake                  <= 1'b0;
         o_comms_en               <= 1'b0;
         o_startup_report         <= 1'b0;
      end else begin
         blk                      <= next_blk;
         s_lamp                   <= next_s_lamp;
         m_lamp                   <= next_m_lamp;
         pins.network_status_lamp <= ~s_lamp;
         pins.network_mode_lamp   <= ~m_lamp;
         pins.usb_dplus_up        <= (next_st == PWR_ON);
         pins.wake_host           <= (st == PWR_ON) && i_need_host;
         o_powered                <= (next_st != PWR_OFF);
         o_awake                  <= (st == PWR_ON) &&
                                     (!(seen_drive | drv_sync[1]) || slp_sync[1]);
         o_comms_en               <= (next_st == PWR_ON);
         o_startup_report         <= next_report;
      end
   end
endmodule

// >>> design/host_ctrl.sv
// Purpose: host end: drives key, reset and sleep pins
// Assumes: one command at a time
// Notes: pulse widths sit inside the module windows
`timescale 1ns/1ps
`include "pwr_ctrl_consts.svh"
module host_ctrl (
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_nrst,
   // pins
   pwr_ctrl_if.host_end    pins,
   // commands
   input  wire logic       i_turn_on,
   input  wire logic       i_turn_off,
   input  wire logic       i_hw_reset,
   input  wire logic       i_sleep,
   input  wire logic       i_sleep_en,
   // status
   output logic            o_busy,
   output logic            o_ids_ok,
   output logic            o_host_wake,
   output logic            o_dplus
);
   import pwr_ctrl_pkg::*;

   logic [16:0]       div;
   logic              tick;
   logic [`CNT_W-1:0] cnt;
   logic [`CNT_W-1:0] next_cnt;
   logic [1:0]        kind;
   logic [1:0]        next_kind;
   logic [1:0]        dp_sync;
   logic [1:0]        wk_sync;

   always_comb begin
      next_cnt  = cnt;
      next_kind = kind;
      if (cnt != '0) begin
         if (tick) next_cnt = cnt - 1'b1;
      end else if (i_turn_on) begin
         next_cnt  = `CNT_W'(`HOST_ON_MS);
         next_kind = 2'h1;
      end else if (i_turn_off) begin
         next_cnt  = `CNT_W'(`HOST_OFF_MS);
         next_kind = 2'h1;
      end else if (i_hw_reset) begin
         next_cnt  = `CNT_W'(`HOST_RST_MS);
         next_kind = 2'h2;
      end else begin
         next_kind = 2'h0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div                     <= 17'h0_0000;
         tick                    <= 1'b0;
         cnt                     <= '0;
         kind                    <= 2'h0;
         dp_sync                 <= 2'h0;
         wk_sync                 <= 2'h0;
         pins.power_key_n        <= 1'b1;
         pins.hw_reset_low_input <= 1'b1;
         pins.sleep_ctrl         <= 1'b1;
         pins.sleep_ctrl_driven  <= 1'b0;
         o_busy                  <= 1'b0;
         o_ids_ok                <= 1'b0;
         o_host_wake             <= 1'b0;
         o_dplus                 <= 1'b0;
      end else begin
         div                     <= (div == 17'(`MS_CYCLES - 1)) ? 17'h0_0000 : div + 17'h0_0001;
         tick                    <= (div == 17'(`MS_CYCLES - 1));
         cnt                     <= next_cnt;
         kind                    <= next_kind;
         dp_sync                 <= {dp_sync[0], pins.usb_dplus_up};
         wk_sync                 <= {wk_sync[0], pins.wake_host};
         pins.power_key_n        <= !(next_cnt != '0 && next_kind == 2'h1);
         pins.hw_reset_low_input <= !(next_cnt != '0 && next_kind == 2'h2);
         pins.sleep_ctrl         <= !i_sleep;
         pins.sleep_ctrl_driven  <= i_sleep_en;
         o_busy                  <= (next_cnt != '0);
         o_ids_ok                <= dp_sync[1];
         o_host_wake             <= wk_sync[1];
         o_dplus                 <= dp_sync[1];
      end
   end
endmodule

// >>> verification/pwr_ctrl_sva.sv
// Purpose: assertions on the pins between host and module ends
// Assumes: one clock, async active-low reset
// Notes: counters measure key and reset pulse lengths
`timescale 1ns/1ps
`include "pwr_ctrl_consts.svh"
module pwr_ctrl_sva (
   // clock and reset
   input wire logic                     i_ref_clk,
   input wire logic                     i_nrst,
   // pins
   input wire logic                     power_key_n,
   input wire logic                     hw_reset_low_input,
   input wire logic                     network_status_lamp,
   input wire logic                     network_mode_lamp,
   input wire logic                     usb_dplus_up,
   input wire logic                     wake_host,
   input wire logic                     sleep_ctrl_driven,
   // module side
   input wire pwr_ctrl_pkg::net_state_t i_net_state,
   input wire logic                     i_need_host,
   input wire logic                     o_powered,
   input wire logic                     o_awake,
   input wire logic                     o_comms_en,
   input wire logic                     o_startup_report
);
   import pwr_ctrl_pkg::*;
   localparam int M = `MS_CYCLES;
   logic [31:0] key_low;
   logic [31:0] next_key_low;
   logic [31:0] rst_low;
   logic [31:0] next_rst_low;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_nrst);
   // low-time counters
   always_comb begin
      next_key_low = power_key_n ? 32'h0000_0000 : key_low + 32'h0000_0001;
      next_rst_low = hw_reset_low_input ? 32'h0000_0000 : rst_low + 32'h0000_0001;
   end
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         key_low <= 32'h0000_0000;
         rst_low <= 32'h0000_0000;
      end else begin
         key_low <= next_key_low;
         rst_low <= next_rst_low;
      end
   end
   chk_dplus_comms: assert property (usb_dplus_up == o_comms_en)
      else $error("dplus and comms enable differ");
   chk_lamps_dark_off: assert property (!o_powered && !$past(o_powered) &&
      !$past(o_powered, 2) |->
      network_status_lamp && network_mode_lamp) else $error("lamp lit while off");
   chk_status_steady: assert property ((o_comms_en && i_net_state == NET_3G_DATA) [*3] |->
      !network_status_lamp && network_mode_lamp) else $error("3g data lamps wrong");
   chk_mode_steady: assert property ((o_comms_en && i_net_state == NET_2G_DATA) [*3] |->
      network_status_lamp && !network_mode_lamp) else $error("2g data lamps wrong");
   chk_mode_dark_3g: assert property ((o_comms_en && i_net_state == NET_3G_REG) [*3] |->
      network_mode_lamp) else $error("mode lamp lit on 3g");
   chk_status_dark: assert property ((o_comms_en && i_net_state inside
      {NET_UPDATE, NET_SEARCH, NET_2G_REG}) [*3] |-> network_status_lamp)
      else $error("status lamp lit");
   chk_awake_undriven: assert property ((o_comms_en && !sleep_ctrl_driven) [*3] |-> o_awake)
      else $error("asleep without sleep input");
   chk_wake_host: assert property ((o_comms_en && i_need_host) [*4] |-> wake_host)
      else $error("host wake missing");
   chk_report_pulse: assert property (o_startup_report |-> o_powered ##1 !o_startup_report)
      else $error("startup report not one cycle");
   chk_key_press_len: assert property ($rose(power_key_n) |->
      (key_low > `TURN_ON_MS * M && key_low < `TURN_ON_MAX_MS * M) ||
      (key_low > `TURN_OFF_MS * M && key_low < `TURN_OFF_MAX_MS * M))
      else $error("key press length outside windows");
   chk_reset_len: assert property ($rose(hw_reset_low_input) |->
      rst_low > `RST_MIN_MS * M && rst_low < `RST_OFF_MS * M)
      else $error("reset pulse length outside window");
endmodule

// >>> verification/power_key_reset_led_control_tb.sv
// Purpose: self-checking bench for host and module control ends
// Assumes: MS_CYCLES cut short in the constants header for runs
// Notes: second pin bundle lets the bench break host pulse limits
`timescale 1ns/1ps
`include "pwr_ctrl_consts.svh"
module power_key_reset_led_control_tb;
   import pwr_ctrl_pkg::*;
   localparam int     M     = `MS_CYCLES;
   localparam longint LIMIT = 64'd22000 * M;
   logic       i_ref_clk;
   logic       i_nrst;
   logic       supply_ok;
   net_state_t net_state;
   logic       need_host;
   logic       turn_on;
   logic       turn_off;
   logic       hw_reset;
   logic       sleep;
   logic       sleep_en;
   logic       powered;
   logic       awake;
   logic       comms_en;
   logic       report;
   logic       busy;
   logic       ids_ok;
   logic       host_wake;
   logic       dplus;
   logic       powered2;
   int         err_count = 0;
   int         n_compared = 0;
   int         n_report = 0;
   longint     cycles = 0;
   pwr_ctrl_if pins ();
   pwr_ctrl_if pins2 ();
   module_ctrl u_module_ctrl (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .pins(pins),
      .i_supply_ok(supply_ok), .i_net_state(net_state), .i_need_host(need_host),
      .o_powered(powered), .o_awake(awake), .o_comms_en(comms_en), .o_startup_report(report));
   module_ctrl u_module_ctrl2 (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .pins(pins2),
      .i_supply_ok(supply_ok), .i_net_state(net_state), .i_need_host(need_host),
      .o_powered(powered2), .o_awake(), .o_comms_en(), .o_startup_report());
   host_ctrl u_host_ctrl (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .pins(pins),
      .i_turn_on(turn_on), .i_turn_off(turn_off), .i_hw_reset(hw_reset), .i_sleep(sleep),
      .i_sleep_en(sleep_en), .o_busy(busy), .o_ids_ok(ids_ok), .o_host_wake(host_wake),
      .o_dplus(dplus));
   pwr_ctrl_sva u_pwr_ctrl_sva (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
      .power_key_n(pins.power_key_n), .hw_reset_low_input(pins.hw_reset_low_input),
      .network_status_lamp(pins.network_status_lamp),
      .network_mode_lamp(pins.network_mode_lamp), .usb_dplus_up(pins.usb_dplus_up),
      .wake_host(pins.wake_host), .sleep_ctrl_driven(pins.sleep_ctrl_driven),
      .i_net_state(net_state), .i_need_host(need_host), .o_powered(powered),
      .o_awake(awake), .o_comms_en(comms_en), .o_startup_report(report));
   initial i_ref_clk = 1'b0;
   always #5 i_ref_clk = ~i_ref_clk;
   // report count and hang guard
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (report === 1'b1) n_report <= n_report + 1;
      if (cycles == LIMIT) begin
         err_count = err_count + 1;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wait_ms(input int n);
      repeat (n * M) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
   endtask
   task automatic check1(input logic got, input logic exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_range(input int got, input int lo, input int hi);
      n_compared = n_compared + 1;
      if (got < lo || got > hi) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask
   // one-cycle host command: 0 on, 1 off, 2 reset
   task automatic pulse(input int k);
      @(posedge i_ref_clk);
      turn_on <= (k == 0);
      turn_off <= (k == 1);
      hw_reset <= (k == 2);
      @(posedge i_ref_clk);
      turn_on <= 1'b0;
      turn_off <= 1'b0;
      hw_reset <= 1'b0;
   endtask
   task automatic pin2(input logic key, input logic rst);
      @(posedge i_ref_clk);
      pins2.power_key_n <= key;
      pins2.hw_reset_low_input <= rst;
   endtask
   task automatic t_power_on;
      pulse(0);
      wait_ms(490);
      check1(powered, 1'b0);
      wait_ms(30);
      check1(powered, 1'b1);
      wait_ms(180);
      check1(pins.power_key_n, 1'b0);
      wait_ms(100);
      check1(pins.power_key_n, 1'b1);
      wait_ms(3650);
      check1(pins.usb_dplus_up, 1'b0);
      wait_ms(110);
      check1(pins.usb_dplus_up, 1'b1);
      check1(comms_en, 1'b1);
      check1(ids_ok, 1'b1);
      $display("test power on done");
   endtask
   task automatic t_lamps;
      net_state_t st [6] = '{NET_3G_REG, NET_3G_DATA, NET_UPDATE, NET_SEARCH,
                             NET_2G_REG, NET_2G_DATA};
      int sgl = `SINGLE_ON_MS + `SINGLE_OFF_MS;
      int dbl = 2 * `DOUBLE_ON_MS + `DOUBLE_GAP_MS + `DOUBLE_OFF_MS;
      int win [6] = '{sgl, 100, 2 * (`FAST_ON_MS + `FAST_OFF_MS), dbl, sgl, 100};
      int es [6] = '{`SINGLE_ON_MS, 100, 0, 0, 0, 0};
      int em [6] = '{0, 0, 2 * `FAST_ON_MS, 2 * `DOUBLE_ON_MS, `SINGLE_ON_MS, 100};
      int sc;
      int mc;
      for (int i = 0; i < 6; i++) begin
         @(posedge i_ref_clk);
         net_state <= st[i];
         wait_ms(5);
         sc = 0;
         mc = 0;
         repeat (win[i] * M) begin
            @(negedge i_ref_clk);
            sc = sc + (pins.network_status_lamp === 1'b0);
            mc = mc + (pins.network_mode_lamp === 1'b0);
         end
         check_range(sc, (es[i] - 2) * M, (es[i] + 2) * M);
         check_range(mc, (em[i] - 2) * M, (em[i] + 2) * M);
      end
      $display("test lamps done");
   endtask
   task automatic t_sleep;
      @(posedge i_ref_clk);
      sleep <= 1'b1;
      wait_ms(5);
      check1(awake, 1'b1);
      @(posedge i_ref_clk);
      sleep_en <= 1'b1;
      wait_ms(5);
      check1(pins.sleep_ctrl, 1'b0);
      check1(awake, 1'b0);
      @(posedge i_ref_clk);
      sleep <= 1'b0;
      need_host <= 1'b1;
      wait_ms(5);
      check1(awake, 1'b1);
      check1(host_wake, 1'b1);
      @(posedge i_ref_clk);
      need_host <= 1'b0;
      wait_ms(5);
      check1(pins.wake_host, 1'b0);
      $display("test sleep and wake done");
   endtask
   task automatic t_hw_reset;
      n_report = 0;
      pulse(2);
      wait_ms(50);
      check1(pins.hw_reset_low_input, 1'b0);
      wait_ms(70);
      check1(pins.hw_reset_low_input, 1'b1);
      check1(comms_en, 1'b0);
      check1(powered, 1'b1);
      wait_ms(3000);
      check1(dplus, 1'b0);
      wait_ms(1200);
      check1(dplus, 1'b1);
      check_range(n_report, 1, 1);
      $display("test hardware reset done");
   endtask
   task automatic t_turn_off;
      pulse(1);
      wait_ms(2450);
      check1(powered, 1'b1);
      wait_ms(110);
      check1(powered, 1'b0);
      check1(pins.usb_dplus_up, 1'b0);
      check1(pins.network_mode_lamp, 1'b1);
      wait_ms(500);
      check1(pins.power_key_n, 1'b1);
      $display("test power off done");
   endtask
   task automatic t_supply;
      @(posedge i_ref_clk);
      supply_ok <= 1'b0;
      pulse(0);
      wait_ms(600);
      check1(powered, 1'b0);
      check1(busy, 1'b1);
      wait_ms(200);
      check1(busy, 1'b0);
      @(posedge i_ref_clk);
      supply_ok <= 1'b1;
      $display("test supply gate done");
   endtask
   task automatic t_faults;
      pin2(1'b0, 1'b1);
      wait_ms(200);
      pin2(1'b1, 1'b1);
      wait_ms(100);
      check1(powered2, 1'b0);
      pin2(1'b0, 1'b1);
      wait_ms(750);
      pin2(1'b1, 1'b1);
      wait_ms(4300);
      check1(pins2.usb_dplus_up, 1'b1);
      pin2(1'b1, 1'b0);
      wait_ms(20);
      pin2(1'b1, 1'b1);
      wait_ms(20);
      check1(pins2.usb_dplus_up, 1'b1);
      pin2(1'b1, 1'b0);
      wait_ms(2100);
      check1(powered2, 1'b0);
      pin2(1'b1, 1'b1);
      wait_ms(50);
      check1(powered2, 1'b0);
      $display("test far-end faults done");
   endtask
   initial begin
      pins2.power_key_n = 1'b1;
      pins2.hw_reset_low_input = 1'b1;
      pins2.sleep_ctrl = 1'b1;
      pins2.sleep_ctrl_driven = 1'b0;
      supply_ok = 1'b1;
      net_state = NET_IDLE;
      need_host = 1'b0;
      turn_on = 1'b0;
      turn_off = 1'b0;
      hw_reset = 1'b0;
      sleep = 1'b0;
      sleep_en = 1'b0;
      i_nrst = 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      @(negedge i_ref_clk);
      check1(pins.network_status_lamp, 1'b1);
      check1(pins.usb_dplus_up, 1'b0);
      check1(powered, 1'b0);
      $display("test reset values done");
      fork
         begin
            t_power_on();
            t_lamps();
            t_sleep();
            t_hw_reset();
            t_turn_off();
            t_supply();
         end
         t_faults();
      join
      finish_test();
   end
endmodule
